// ===== hw/usb_bridge_config_registers.sv
// Purpose: Byte-wide configuration register bank of a USB bridge on AHB-Lite.
// Assumes: One clock; all pin inputs synchronous to clk_sys; single word transfers.
// Notes:   Writes finish with no wait state, reads insert exactly one wait state.
// Function
// - Source select zero clocks FIFOs from interface pin, one from internal clock.
// - Internal FIFO clock is 30 MHz on frequency bit zero, 48 MHz on one.
// - Interface clock pin floats while output enable is zero, driven when one.
// - Invert bit one makes the falling interface clock edge the active one.
// - Synchronous mode: control pins are read and write enables on the clock.
// - Asynchronous mode, the reset state: control pins are direct strobes.
// - Per endpoint two-bit iso packets-per-frame, one to three, reset one.
// - Two read-only flag registers, reset 0x22 and 0x66.
// - Write-only register: top nibble flushes FIFOs, low nibble forces packet end.
// - Control endpoint byte count is an eight-bit read-write register.
// - Setup register reads eight setup bytes; a write stalls control endpoint.
// - Low pointer, high pointer and data registers give indirect access.
// - Indirect polarity register: six writable bits, top two read zero, reset zero.
//
// Design decision made here: the AHB-Lite interface to the registers.
module usb_bridge_config_registers #(
   parameter int DESCRIPTOR_RAM_DEPTH = bridge_regs_pkg::DESCRIPTOR_RAM_DEPTH_DEF,
   parameter int EP0_DEPTH  = bridge_regs_pkg::EP0_DEPTH_DEF
) (
   input  wire logic                         clk_sys,
   input  wire logic                         nrst,
   input  wire logic                         clk_en,
   input  wire logic                         hsel,
   input  wire logic [31:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic      [31:0]                  hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   input  wire logic                         internal_clk_30,
   input  wire logic                         internal_clk_48,
   input  wire logic                         interface_clock_pin_in,
   output logic                              interface_clock_pin_out,
   output logic                              interface_clock_pin_oe,
   output logic                              fifo_clock,
   output logic                              fifo_sync_mode,
   input  wire logic                         fifo_read_strobe_pin,
   input  wire logic                         fifo_write_strobe_pin,
   input  wire logic                         fifo_output_enable_pin,
   input  wire logic                         packet_commit_pin,
   output logic                              fifo_read_enable,
   output logic                              fifo_write_enable,
   output logic                              fifo_read_strobe,
   output logic                              fifo_write_strobe,
   output logic                              fifo_output_enable,
   output logic                              packet_commit,
   input  bridge_regs_pkg::fifo_flags_t      fifo_flags,
   output logic      [3:0]                   fifo_empty_flag,
   output logic      [3:0]                   fifo_full_flag,
   output logic      [3:0][1:0]              iso_packets_per_frame,
   output bridge_regs_pkg::strobes_t         strobes,
   input  wire logic [10:0]                  frame_count,
   input  wire logic [2:0]                   sub_frame_count,
   input  wire logic [6:0]                   function_addr,
   input  wire logic                         high_speed_granted,
   input  wire logic [63:0]                  setup_packet,
   input  wire logic [7:0]                   usb_event,
   input  wire logic                         toggle_state,
   output logic      [6:0]                   toggle_control,
   input  wire logic [8:0]                   descriptor_ram_rd_addr,
   output logic      [7:0]                   descriptor_ram_rd_data,
   output logic                              irq
);
   localparam int DW = $clog2(DESCRIPTOR_RAM_DEPTH);
   localparam int EW = $clog2(EP0_DEPTH);

   if (DESCRIPTOR_RAM_DEPTH < 2 || DESCRIPTOR_RAM_DEPTH > 512) begin : g_chk_descriptor_ram
      $error("Descriptor depth must lie in 2 to 512");
   end
   if (EP0_DEPTH < 2 || EP0_DEPTH > 256) begin : g_chk_ep0
      $error("Control buffer depth must lie in 2 to 256");
   end

   typedef struct packed {
      logic [7:0]      cfg;
      logic [3:0][1:0] iso;
      logic [7:0]      flags24;
      logic [7:0]      flags68;
      logic [7:0]      int_en;
      logic [7:0]      int_stat;
      logic [7:0]      byte_count;
      logic [15:0]     ptr;
      logic [5:0]      polar;
      logic [6:0]      toggle;
      logic [DW-1:0]   descriptor_ram_ptr;
      logic [EW-1:0]   ep0_ptr;
      logic [2:0]      setup_ptr;
      logic            ph_valid;
      logic            ph_write;
      logic            ph_mapped;
      logic [5:0]      ph_idx;
      logic            rd_wait;
      logic [7:0]      rdata;
      bridge_regs_pkg::strobes_t strb;
   } state_t;

   state_t     st;
   state_t     next_st;
   logic [7:0] descriptor_ram_mem [DESCRIPTOR_RAM_DEPTH];
   logic [7:0] ep0_mem [EP0_DEPTH];
   logic       descriptor_ram_we;
   logic       ep0_we;
   logic [7:0] wbyte;
   logic [7:0] rd_mux;
   logic [7:0] flags24_now;
   logic [7:0] flags68_now;
   logic [7:0] events;
   logic       accept;
   logic       fifo_clk_src;

   assign wbyte = hwdata[7:0];
   assign accept = hsel && htrans[1] && hready;
   assign hreadyout = !st.rd_wait;
   assign hresp = 1'b0;
   assign hrdata = {24'h0, st.rdata};
   assign irq = |(st.int_stat & st.int_en);
   assign iso_packets_per_frame = st.iso;
   assign strobes = st.strb;
   assign toggle_control = st.toggle;

   // The clock selection is a plain mux; a glitch-free switch belongs to the clock cell.
   assign fifo_clk_src = st.cfg[bridge_regs_pkg::CFG_FREQ] ? internal_clk_48 : internal_clk_30;
   assign fifo_clock = (st.cfg[bridge_regs_pkg::CFG_SRC] ? fifo_clk_src : interface_clock_pin_in)
                       ^ st.cfg[bridge_regs_pkg::CFG_INV];
   assign interface_clock_pin_out = fifo_clk_src ^ st.cfg[bridge_regs_pkg::CFG_INV];
   assign interface_clock_pin_oe = st.cfg[bridge_regs_pkg::CFG_OE];

   assign fifo_sync_mode = !st.cfg[bridge_regs_pkg::CFG_ASYNCHRONOUS_FIFO_MODE];
   always_comb begin
      logic rd_act;
      logic wr_act;
      rd_act = fifo_read_strobe_pin ~^ st.polar[bridge_regs_pkg::POL_FIFO_READ_STROBE_PIN];
      wr_act = fifo_write_strobe_pin ~^ st.polar[bridge_regs_pkg::POL_FIFO_WRITE_STROBE_PIN];
      fifo_read_enable = fifo_sync_mode && rd_act;
      fifo_write_enable = fifo_sync_mode && wr_act;
      fifo_read_strobe = !fifo_sync_mode && rd_act;
      fifo_write_strobe = !fifo_sync_mode && wr_act;
      fifo_output_enable = fifo_output_enable_pin ~^ st.polar[bridge_regs_pkg::POL_FIFO_OUTPUT_ENABLE_PIN];
      packet_commit = packet_commit_pin ~^ st.polar[bridge_regs_pkg::POL_PACKET_COMMIT_PIN];
      fifo_empty_flag = fifo_flags.empty ^ {4{!st.polar[bridge_regs_pkg::POL_EF]}};
      fifo_full_flag = fifo_flags.full ^ {4{!st.polar[bridge_regs_pkg::POL_FF]}};
   end

   assign flags24_now = {1'b0, fifo_flags.programmable[1], fifo_flags.empty[1], fifo_flags.full[1],
                         1'b0, fifo_flags.programmable[0], fifo_flags.empty[0], fifo_flags.full[0]};
   assign flags68_now = {1'b0, fifo_flags.programmable[3], fifo_flags.empty[3], fifo_flags.full[3],
                         1'b0, fifo_flags.programmable[2], fifo_flags.empty[2], fifo_flags.full[2]};
   always_comb begin
      events = usb_event;
      events[bridge_regs_pkg::INT_FLAGS] = usb_event[bridge_regs_pkg::INT_FLAGS]
         || (flags24_now != st.flags24) || (flags68_now != st.flags68);
   end

   // Read data is formed in the wait cycle, after any write of the previous transfer has landed.
   always_comb begin
      rd_mux = 8'h00;
      unique case (st.ph_idx)
         bridge_regs_pkg::IDX_CFG:      rd_mux = st.cfg;
         bridge_regs_pkg::IDX_FLAGS24:  rd_mux = st.flags24;
         bridge_regs_pkg::IDX_FLAGS68:  rd_mux = st.flags68;
         bridge_regs_pkg::IDX_FRAME_H:  rd_mux = {5'h00, frame_count[10:8]};
         bridge_regs_pkg::IDX_FRAME_L:  rd_mux = frame_count[7:0];
         bridge_regs_pkg::IDX_SUBFRAME: rd_mux = {5'h00, sub_frame_count};
         bridge_regs_pkg::IDX_FUNCTION_ADDRESS:   rd_mux = {high_speed_granted, function_addr};
         bridge_regs_pkg::IDX_INTEN:    rd_mux = st.int_en;
         bridge_regs_pkg::IDX_INTSTAT:  rd_mux = st.int_stat;
         bridge_regs_pkg::IDX_CONTROL_EP_BUFFER:   rd_mux = ep0_mem[st.ep0_ptr];
         bridge_regs_pkg::IDX_SETUP:    rd_mux = setup_packet[{st.setup_ptr, 3'h0} +: 8];
         bridge_regs_pkg::IDX_CONTROL_EP_BYTE_COUNT:    rd_mux = st.byte_count;
         bridge_regs_pkg::IDX_PTR_LO:   rd_mux = st.ptr[7:0];
         bridge_regs_pkg::IDX_PTR_HI:   rd_mux = st.ptr[15:8];
         bridge_regs_pkg::IDX_IND_DATA: begin
            if (st.ptr == bridge_regs_pkg::IND_POLAR) begin
               rd_mux = {2'b00, st.polar};
            end else if (st.ptr == bridge_regs_pkg::IND_TOGGLE) begin
               rd_mux = {toggle_state, st.toggle};
            end
         end
         default: begin
            if (st.ph_idx >= bridge_regs_pkg::IDX_ISO2 && st.ph_idx <= bridge_regs_pkg::IDX_ISO8) begin
               rd_mux = {6'h00, st.iso[st.ph_idx[1:0] - 2'd2]};
            end
         end
      endcase
   end

   always_comb begin
      logic wr_now;
      logic rd_now;
      logic [1:0] ep;
      next_st = st;
      wr_now = st.ph_valid && st.ph_write && st.ph_mapped;
      rd_now = st.rd_wait;
      ep = st.ph_idx[1:0] - 2'd2;
      descriptor_ram_we = 1'b0;
      ep0_we = 1'b0;
      next_st.strb = '0;
      next_st.flags24 = flags24_now;
      next_st.flags68 = flags68_now;
      next_st.int_stat = st.int_stat;
      if (rd_now && st.ph_idx == bridge_regs_pkg::IDX_INTSTAT) begin
         next_st.int_stat = 8'h00;
      end
      // An event in the clearing cycle is kept: set is applied after the clear.
      next_st.int_stat = next_st.int_stat | events;
      if (usb_event[bridge_regs_pkg::INT_SETUP]) begin
         next_st.setup_ptr = 3'h0;
      end
      if (wr_now) begin
         unique case (st.ph_idx)
            bridge_regs_pkg::IDX_CFG:      next_st.cfg = wbyte;
            bridge_regs_pkg::IDX_INTEN:    next_st.int_en = wbyte;
            bridge_regs_pkg::IDX_CONTROL_EP_BYTE_COUNT: begin
               next_st.byte_count = wbyte;
               next_st.ep0_ptr = '0;
            end
            bridge_regs_pkg::IDX_PKTFLUSH: begin
               next_st.strb.flush = wbyte[7:4];
               next_st.strb.packet_end = 1'b1;
               next_st.strb.packet_end_ep = wbyte[3:0];
            end
            bridge_regs_pkg::IDX_SETUP:    next_st.strb.stall = 1'b1;
            bridge_regs_pkg::IDX_DESCRIPTOR_RAM: begin
               descriptor_ram_we = 1'b1;
               next_st.descriptor_ram_ptr = (st.descriptor_ram_ptr == DW'(DESCRIPTOR_RAM_DEPTH - 1)) ? '0 : st.descriptor_ram_ptr + 1'b1;
            end
            bridge_regs_pkg::IDX_CONTROL_EP_BUFFER: begin
               ep0_we = 1'b1;
               next_st.ep0_ptr = st.ep0_ptr + 1'b1;
            end
            bridge_regs_pkg::IDX_PTR_LO:   next_st.ptr[7:0] = wbyte;
            bridge_regs_pkg::IDX_PTR_HI:   next_st.ptr[15:8] = wbyte;
            bridge_regs_pkg::IDX_IND_DATA: begin
               if (st.ptr == bridge_regs_pkg::IND_POLAR) begin
                  next_st.polar = wbyte[5:0];
               end else if (st.ptr == bridge_regs_pkg::IND_TOGGLE) begin
                  next_st.toggle = wbyte[6:0];
               end
            end
            default: begin
               // Zero is outside the legal range of one to three and is ignored, as are read-only indices.
               if (st.ph_idx >= bridge_regs_pkg::IDX_ISO2 && st.ph_idx <= bridge_regs_pkg::IDX_ISO8
                   && wbyte[1:0] != 2'h0) begin
                  next_st.iso[ep] = wbyte[1:0];
               end
            end
         endcase
      end
      if (rd_now) begin
         next_st.rdata = rd_mux;
         if (st.ph_idx == bridge_regs_pkg::IDX_CONTROL_EP_BUFFER) begin
            next_st.ep0_ptr = st.ep0_ptr + 1'b1;
         end
         if (st.ph_idx == bridge_regs_pkg::IDX_SETUP) begin
            next_st.setup_ptr = st.setup_ptr + 1'b1;
         end
      end
      next_st.rd_wait = 1'b0;
      next_st.ph_valid = 1'b0;
      if (accept) begin
         next_st.ph_valid = 1'b1;
         next_st.ph_write = hwrite;
         next_st.ph_idx = haddr[7:2];
         next_st.ph_mapped = (haddr[31:8] == 24'h0) && (hwrite ? haddr[7:2] != bridge_regs_pkg::IDX_FLAGS24
            && haddr[7:2] != bridge_regs_pkg::IDX_FLAGS68 : 1'b1);
         next_st.rd_wait = !hwrite;
         if (!hwrite && haddr[31:8] != 24'h0) begin
            next_st.ph_idx = 6'h00;
         end
      end
   end

   always_ff @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         st <= '0;
         st.cfg <= bridge_regs_pkg::CFG_RST;
         st.iso <= {4{bridge_regs_pkg::ISO_RST}};
         st.flags24 <= bridge_regs_pkg::FLAGS24_RST;
         st.flags68 <= bridge_regs_pkg::FLAGS68_RST;
         st.int_en <= bridge_regs_pkg::INTEN_RST;
         st.polar <= bridge_regs_pkg::POLAR_RST;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // Buffers hold no reset; their contents are undefined until written.
   always_ff @(posedge clk_sys) begin
      if (clk_en && descriptor_ram_we) begin
         descriptor_ram_mem[st.descriptor_ram_ptr] <= wbyte;
      end
      if (clk_en && ep0_we) begin
         ep0_mem[st.ep0_ptr] <= wbyte;
      end
      if (clk_en) begin
         descriptor_ram_rd_data <= descriptor_ram_mem[descriptor_ram_rd_addr[DW-1:0]];
      end
   end

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!nrst || !clk_en);

   a_clk_source_sel: assert property (st.cfg[bridge_regs_pkg::CFG_SRC] == 1'b0 |->
      fifo_clock == (interface_clock_pin_in ^ st.cfg[bridge_regs_pkg::CFG_INV])) else $error("source mux wrong");
   a_clk_freq_sel: assert property (st.cfg[bridge_regs_pkg::CFG_SRC] && !st.cfg[bridge_regs_pkg::CFG_INV] |->
      fifo_clock == (st.cfg[bridge_regs_pkg::CFG_FREQ] ? internal_clk_48 : internal_clk_30)) else $error("freq wrong");
   a_clk_pin_oe: assert property (accept && hwrite && haddr[7:2] == bridge_regs_pkg::IDX_CFG
      ##1 1'b1 |=> interface_clock_pin_oe == $past(wbyte[bridge_regs_pkg::CFG_OE])) else $error("pin oe wrong");
   a_sync_enables: assert property (fifo_read_enable |-> !st.cfg[bridge_regs_pkg::CFG_ASYNCHRONOUS_FIFO_MODE]
      && !fifo_read_strobe) else $error("sync enable in asynchronous_fifo_mode mode");
   a_asynchronous_fifo_mode_strobes: assert property (st.cfg[bridge_regs_pkg::CFG_ASYNCHRONOUS_FIFO_MODE] |->
      !fifo_read_enable && !fifo_write_enable) else $error("enable in asynchronous_fifo_mode mode");
   a_iso_range: assert property (st.iso[0] != 2'h0 && st.iso[3] != 2'h0) else $error("iso count zero");
   a_flag_snapshot: assert property (##1 st.flags24 == $past(flags24_now)) else $error("flags stale");
   a_flush_pulse: assert property (accept && hwrite && haddr[7:2] == bridge_regs_pkg::IDX_PKTFLUSH
      |=> ##1 strobes.packet_end && strobes.flush == $past(wbyte[7:4]) ##1 !strobes.packet_end)
      else $error("flush pulse wrong");
   a_setup_stall: assert property (accept && hwrite && haddr[7:2] == bridge_regs_pkg::IDX_SETUP
      |=> ##1 strobes.stall) else $error("stall missing");
   a_polar_top: assert property (st.ph_idx == bridge_regs_pkg::IDX_IND_DATA && st.rd_wait
      && st.ptr == bridge_regs_pkg::IND_POLAR |=> hrdata[7:6] == 2'b00 && hrdata[5:0] == $past(st.polar))
      else $error("polarity read wrong");
   a_read_wait: assert property (accept && !hwrite |=> !hreadyout ##1 hreadyout) else $error("read wait wrong");
   a_event_sticky: assert property (usb_event != 8'h00 |=> (st.int_stat & $past(usb_event)) == $past(usb_event))
      else $error("event not latched");

   c_read_cycle: cover property (accept && !hwrite ##2 hreadyout);
   c_flush_write: cover property (strobes.packet_end && strobes.flush != 4'h0);
   c_indirect_write: cover property (st.ptr == bridge_regs_pkg::IND_POLAR && st.polar != 6'h00);
   c_irq_raised: cover property (!irq ##1 irq);
endmodule

// ===== hw/bridge_regs_pkg.sv
// Purpose: Shared constants and carrier types of the USB bridge register bank.
// Assumes: AHB-Lite word addressing, byte address is four times the register index.
// Notes:   Indirect addresses are the values written to the two pointer registers.
package bridge_regs_pkg;
   localparam logic [5:0] IDX_CFG      = 6'h01;
   localparam logic [5:0] IDX_ISO2     = 6'h1a;
   localparam logic [5:0] IDX_ISO8     = 6'h1d;
   localparam logic [5:0] IDX_FLAGS24  = 6'h1e;
   localparam logic [5:0] IDX_FLAGS68  = 6'h1f;
   localparam logic [5:0] IDX_PKTFLUSH = 6'h20;
   localparam logic [5:0] IDX_FRAME_H  = 6'h2a;
   localparam logic [5:0] IDX_FRAME_L  = 6'h2b;
   localparam logic [5:0] IDX_SUBFRAME = 6'h2c;
   localparam logic [5:0] IDX_FUNCTION_ADDRESS   = 6'h2d;
   localparam logic [5:0] IDX_INTEN    = 6'h2e;
   localparam logic [5:0] IDX_DESCRIPTOR_RAM     = 6'h30;
   localparam logic [5:0] IDX_CONTROL_EP_BUFFER   = 6'h31;
   localparam logic [5:0] IDX_SETUP    = 6'h32;
   localparam logic [5:0] IDX_CONTROL_EP_BYTE_COUNT    = 6'h33;
   localparam logic [5:0] IDX_PTR_LO   = 6'h3a;
   localparam logic [5:0] IDX_PTR_HI   = 6'h3b;
   localparam logic [5:0] IDX_IND_DATA = 6'h3c;
   localparam logic [5:0] IDX_INTSTAT  = 6'h3d;

   localparam logic [15:0] IND_POLAR  = 16'he609;
   localparam logic [15:0] IND_TOGGLE = 16'he683;

   localparam logic [7:0] CFG_RST     = 8'hc9;
   localparam logic [1:0] ISO_RST     = 2'h1;
   localparam logic [7:0] FLAGS24_RST = 8'h22;
   localparam logic [7:0] FLAGS68_RST = 8'h66;
   localparam logic [7:0] INTEN_RST   = 8'hff;
   localparam logic [5:0] POLAR_RST   = 6'h00;

   // Interface configuration bit positions.
   localparam int CFG_SRC   = 7;
   localparam int CFG_FREQ  = 6;
   localparam int CFG_OE    = 5;
   localparam int CFG_INV   = 4;
   localparam int CFG_ASYNCHRONOUS_FIFO_MODE = 3;
   // Pin polarity bit positions; a one makes the pin active high.
   localparam int POL_PACKET_COMMIT_PIN = 5;
   localparam int POL_FIFO_OUTPUT_ENABLE_PIN   = 4;
   localparam int POL_FIFO_READ_STROBE_PIN   = 3;
   localparam int POL_FIFO_WRITE_STROBE_PIN   = 2;
   localparam int POL_EF     = 1;
   localparam int POL_FF     = 0;
   // Interrupt bit of the flag-change event; setup event is the top bit.
   localparam int INT_FLAGS = 5;
   localparam int INT_SETUP = 7;

   localparam int DESCRIPTOR_RAM_DEPTH_DEF = 500;
   localparam int EP0_DEPTH_DEF  = 64;

   typedef struct packed {
      logic [3:0] programmable;
      logic [3:0] empty;
      logic [3:0] full;
   } fifo_flags_t;

   typedef struct packed {
      logic [3:0] flush;
      logic       packet_end;
      logic [3:0] packet_end_ep;
      logic       stall;
   } strobes_t;
endpackage

// ===== bench/fifo_far_side.sv
// Purpose: Far-side model of the FIFO pins: interface clock and flag levels.
// Assumes: Flags hold the empty pattern, so the flag registers keep their reset image.
// Notes:   The clock stands low while run is low.
module fifo_far_side (
   input  wire logic                    clk_sys,
   input  wire logic                    run,
   output logic                         ext_clk,
   output bridge_regs_pkg::fifo_flags_t flags
);
   timeunit 1ns;
   timeprecision 1ns;
   always_ff @(posedge clk_sys) ext_clk <= run & !ext_clk;
   assign flags = '{programmable: 4'hc, empty: 4'hf, full: 4'h0};
endmodule

// ===== bench/tb_usb_bridge_config_registers.sv
// Purpose: Self-checking bench of the USB bridge register bank.
// Assumes: Write data phase is one cycle, read data phase two.
// Notes:   Internal clock inputs are held at different levels to tell them apart.
module tb_usb_bridge_config_registers;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys = 0, nrst = 0, clk_en = 1, hsel = 0, hwrite = 0, run = 0;
   logic hreadyout, hresp, irq, interface_clock_pin_in, interface_clock_pin_out, interface_clock_pin_oe;
   logic internal_clk_30 = 1, internal_clk_48 = 0, high_speed_granted = 1, toggle_state = 0;
   logic fifo_read_strobe_pin = 0, fifo_write_strobe_pin = 1, fifo_output_enable_pin = 1, packet_commit_pin = 1;
   logic fifo_clock, fifo_sync_mode, fifo_read_enable, fifo_write_enable, fifo_read_strobe;
   logic fifo_write_strobe, fifo_output_enable, packet_commit;
   logic [31:0] haddr = 0, hwdata = 0, hrdata;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2, sub_frame_count = 3'h6;
   logic [3:0]  fifo_empty_flag, fifo_full_flag;
   logic [3:0][1:0] iso_packets_per_frame;
   logic [10:0] frame_count = 11'h5a3;
   logic [6:0]  function_addr = 7'h2b, toggle_control;
   logic [63:0] setup_packet = 64'h8877665544332211;
   logic [7:0]  usb_event = 0, descriptor_ram_rd_data, rd;
   logic [8:0]  descriptor_ram_rd_addr = 0;
   bridge_regs_pkg::fifo_flags_t fifo_flags;
   bridge_regs_pkg::strobes_t    strobes;
   int mismatches = 0, num_checks = 0, cycles = 0;

   usb_bridge_config_registers i_dut (.*, .hready(hreadyout));
   fifo_far_side i_far (.clk_sys(clk_sys), .run(run), .ext_clk(interface_clock_pin_in), .flags(fifo_flags));

   always #10 clk_sys = !clk_sys;

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk8({7'h0, got}, {7'h0, exp});
   endtask

   // One AHB single transfer; read data lands in rd.
   task automatic bus(input logic [5:0] idx, input logic w, input logic [7:0] d);
      @(posedge clk_sys);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {24'h0, idx, 2'h0};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge clk_sys); while (hreadyout !== 1'b1);
      rd = hrdata[7:0];
   endtask

   task automatic pulse(input logic [7:0] ev);
      @(posedge clk_sys);
      usb_event <= ev;
      @(posedge clk_sys);
      usb_event <= 8'h00;
   endtask

   task automatic t_map();
      logic [5:0] idx [12] = '{bridge_regs_pkg::IDX_CFG, bridge_regs_pkg::IDX_ISO2, bridge_regs_pkg::IDX_ISO8,
         bridge_regs_pkg::IDX_FLAGS24, bridge_regs_pkg::IDX_FLAGS68, bridge_regs_pkg::IDX_INTEN,
         bridge_regs_pkg::IDX_FRAME_H, bridge_regs_pkg::IDX_FRAME_L, bridge_regs_pkg::IDX_SUBFRAME,
         bridge_regs_pkg::IDX_FUNCTION_ADDRESS, bridge_regs_pkg::IDX_PKTFLUSH, 6'h3e};
      logic [7:0] exp [12] = '{8'hc9, 8'h01, 8'h01, 8'h22, 8'h66, 8'hff, 8'h05, 8'ha3, 8'h06, 8'hab, 8'h00, 8'h00};
      bus(bridge_regs_pkg::IDX_FLAGS24, 1'b1, 8'h03);
      bus(bridge_regs_pkg::IDX_FUNCTION_ADDRESS, 1'b1, 8'h03);
      foreach (idx[i]) begin
         bus(idx[i], 1'b0, 8'h00);
         chk8(rd, exp[i]);
      end
      chk1(hresp, 1'b0);
      $display("test map done");
   endtask

   task automatic t_iso();
      logic [7:0] v;
      for (logic [5:0] a = bridge_regs_pkg::IDX_ISO2; a <= bridge_regs_pkg::IDX_ISO8; a++) begin
         v = {6'h0, a[0] ? 2'h3 : 2'h2};
         bus(a, 1'b1, v);
         bus(a, 1'b1, 8'h00);
         bus(a, 1'b0, 8'h00);
         chk8(rd, v);
         chk8({6'h0, iso_packets_per_frame[a[1:0] - 2'h2]}, v);
      end
      $display("test iso done");
   endtask

   task automatic t_config();
      logic [7:0] cfg [5] = '{8'h49, 8'h59, 8'h89, 8'hd9, 8'hf1};
      logic       sel;
      run <= 1'b1;
      foreach (cfg[i]) begin
         bus(bridge_regs_pkg::IDX_CFG, 1'b1, cfg[i]);
         #1;
         sel = cfg[i][6] ? internal_clk_48 : internal_clk_30;
         chk1(fifo_clock, (cfg[i][7] ? sel : interface_clock_pin_in) ^ cfg[i][4]);
         chk1(interface_clock_pin_oe, cfg[i][5]);
         chk1(interface_clock_pin_out, sel ^ cfg[i][4]);
         chk1(fifo_read_enable, !cfg[i][3]);
         chk1(fifo_sync_mode, !cfg[i][3]);
         chk1(fifo_read_strobe, cfg[i][3]);
      end
      bus(bridge_regs_pkg::IDX_CFG, 1'b1, bridge_regs_pkg::CFG_RST);
      run <= 1'b0;
      $display("test config done");
   endtask

   task automatic t_flush();
      bus(bridge_regs_pkg::IDX_PKTFLUSH, 1'b1, 8'ha5);
      clk_en <= 1'b0;
      #1;
      chk8({strobes.flush, strobes.packet_end_ep}, 8'ha5);
      chk1(strobes.packet_end, 1'b1);
      // A low clock enable must hold the strobe pulse for as long as it stays low.
      @(posedge clk_sys);
      clk_en <= 1'b1;
      #1;
      chk1(strobes.packet_end, 1'b1);
      @(posedge clk_sys);
      #1;
      chk8({strobes.flush, strobes.packet_end_ep}, 8'h00);
      chk1(strobes.packet_end, 1'b0);
      $display("test flush done");
   endtask

   task automatic t_setup();
      bus(bridge_regs_pkg::IDX_CONTROL_EP_BYTE_COUNT, 1'b1, 8'h5a);
      bus(bridge_regs_pkg::IDX_CONTROL_EP_BYTE_COUNT, 1'b0, 8'h00);
      chk8(rd, 8'h5a);
      pulse(8'h80);
      for (int i = 0; i < 8; i++) begin
         bus(bridge_regs_pkg::IDX_SETUP, 1'b0, 8'h00);
         chk8(rd, setup_packet[8*i +: 8]);
      end
      bus(bridge_regs_pkg::IDX_SETUP, 1'b1, 8'h00);
      #1;
      chk1(strobes.stall, 1'b1);
      $display("test setup done");
   endtask

   task automatic t_buffers();
      bus(bridge_regs_pkg::IDX_DESCRIPTOR_RAM, 1'b1, 8'h3c);
      bus(bridge_regs_pkg::IDX_DESCRIPTOR_RAM, 1'b1, 8'h7e);
      descriptor_ram_rd_addr <= 9'h001;
      repeat (2) @(posedge clk_sys);
      #1;
      chk8(descriptor_ram_rd_data, 8'h7e);
      bus(bridge_regs_pkg::IDX_CONTROL_EP_BYTE_COUNT, 1'b1, 8'h02);
      bus(bridge_regs_pkg::IDX_CONTROL_EP_BUFFER, 1'b1, 8'h4d);
      bus(bridge_regs_pkg::IDX_CONTROL_EP_BUFFER, 1'b1, 8'hb2);
      bus(bridge_regs_pkg::IDX_CONTROL_EP_BYTE_COUNT, 1'b1, 8'h02);
      bus(bridge_regs_pkg::IDX_CONTROL_EP_BUFFER, 1'b0, 8'h00);
      chk8(rd, 8'h4d);
      bus(bridge_regs_pkg::IDX_CONTROL_EP_BUFFER, 1'b0, 8'h00);
      chk8(rd, 8'hb2);
      $display("test buffers done");
   endtask

   task automatic t_indirect();
      bus(bridge_regs_pkg::IDX_PTR_LO, 1'b1, 8'h09);
      bus(bridge_regs_pkg::IDX_PTR_HI, 1'b1, 8'he6);
      bus(bridge_regs_pkg::IDX_IND_DATA, 1'b0, 8'h00);
      chk8(rd, 8'h00);
      chk1(packet_commit, 1'b0);
      chk8({4'h0, fifo_full_flag}, 8'h0f);
      // Write polarity stays active low, so the idle write strobe pin never reads as a FIFO write.
      bus(bridge_regs_pkg::IDX_IND_DATA, 1'b1, 8'hfb);
      bus(bridge_regs_pkg::IDX_IND_DATA, 1'b0, 8'h00);
      chk8(rd, 8'h3b);
      chk1(packet_commit, 1'b1);
      chk8({4'h0, fifo_empty_flag}, 8'h0f);
      chk1(fifo_write_strobe, 1'b0);
      bus(bridge_regs_pkg::IDX_PTR_LO, 1'b1, 8'h83);
      bus(bridge_regs_pkg::IDX_IND_DATA, 1'b1, 8'hd5);
      bus(bridge_regs_pkg::IDX_IND_DATA, 1'b0, 8'h00);
      chk8(rd, 8'h55);
      chk8({1'b0, toggle_control}, 8'h55);
      $display("test indirect done");
   endtask

   task automatic t_irq();
      bus(bridge_regs_pkg::IDX_INTSTAT, 1'b0, 8'h00);
      chk8(rd & 8'h80, 8'h80);
      bus(bridge_regs_pkg::IDX_INTEN, 1'b1, 8'h00);
      pulse(8'h01);
      @(posedge clk_sys);
      #1;
      chk1(irq, 1'b0);
      bus(bridge_regs_pkg::IDX_INTEN, 1'b1, 8'h01);
      @(posedge clk_sys);
      #1;
      chk1(irq, 1'b1);
      bus(bridge_regs_pkg::IDX_INTSTAT, 1'b0, 8'h00);
      chk8(rd, 8'h01);
      @(posedge clk_sys);
      #1;
      chk1(irq, 1'b0);
      $display("test irq done");
   endtask

   // Ceiling sits far above the few hundred cycles that the tests take.
   always @(posedge clk_sys) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         stop_test();
      end
   end

   initial begin
      repeat (20) @(posedge clk_sys);
      nrst <= 1'b1;
      t_map();
      t_iso();
      t_config();
      t_flush();
      t_setup();
      t_buffers();
      t_indirect();
      t_irq();
      stop_test();
   end
endmodule
